/* File: logic/icl_pkg.sv */
/*
 * Constants and carrier types for the interrupt level and flag register slice.
 * Assumes one system clock, an active-low asynchronous reset, and a simple
 * strobe-based register port driven by the processor core.
 */
package icl_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [15:0] ICL_OFS_CONV_LEVEL = 16'h42ea;
    localparam logic [15:0] ICL_OFS_SER1_LEVEL = 16'h42f2;
    localparam logic [15:0] ICL_OFS_REMOTE_LEVEL = 16'h42f4;
    localparam logic [15:0] ICL_OFS_FLAG = 16'h4300;
    localparam logic [15:0] ICL_OFS_PORT_MODE = 16'h4380;
    localparam logic [15:0] ICL_OFS_MASK = 16'h4390;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int ICL_POS_CONV_LEVEL = 8;
    localparam int ICL_POS_SER1_LEVEL = 0;
    localparam int ICL_POS_REMOTE_LEVEL = 0;
    localparam int ICL_POS_I2C_MASTER = 15;
    localparam int ICL_POS_SERIAL_CH0 = 14;
    localparam int ICL_POS_UART = 12;
    localparam int ICL_POS_TIMER_A = 11;
    localparam int ICL_POS_TIMER_B = 10;
    localparam int ICL_POS_TIMER_C = 9;
    localparam int ICL_POS_TIMER_D = 8;
    localparam int ICL_POS_PORT = 0;
    localparam int ICL_NUM_PORTS = 8;

    // implemented bits of the flag register; bit 13 is reserved
    localparam logic [15:0] ICL_FLAG_BITS = 16'hdfff;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [2:0] ICL_RST_LEVEL = 3'h0;
    localparam logic [15:0] ICL_RST_FLAG = 16'h0000;
    localparam logic [7:0] ICL_RST_PORT_MODE = 8'h00;
    localparam logic [15:0] ICL_RST_MASK = 16'h0000;
    localparam logic [15:0] ICL_RST_RDATA = 16'h0000;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic i2c_master;
        logic serial_ch0;
        logic uart;
        logic timer_a;
        logic timer_b;
        logic timer_c;
        logic timer_d;
    } icl_periph_req_t;

    typedef struct packed {
        logic [2:0] conv_range_level;
        logic [2:0] serial_ch1_level;
        logic [2:0] remote_ctrl_level;
    } icl_levels_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } icl_bus_req_t;

endpackage

/* File: logic/icl_regs.sv */
/*
 * Interrupt level fields and interrupt flag register with sticky peripheral and pulse-mode port flags,
 * a mask register and one level interrupt output.
 * Assumes peripheral requests are one-cycle pulses on CLK_SYS and port
 * inputs are asynchronous active-high pins.
 */
// The plain strobed port was decided locally.
`timescale 1ns/10ps

module icl_regs (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // register port
    input wire icl_pkg::icl_bus_req_t BUS,
    output logic [15:0] RDATA,
    // request sources
    input wire icl_pkg::icl_periph_req_t PERIPH_REQ,
    input wire logic [7:0] PORT_IN,
    // towards the core
    output logic [15:0] FLAGS,
    output icl_pkg::icl_levels_t LEVELS,
    output logic IRQ
);
    import icl_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] port_meta;
    logic [7:0] port_sync;
    logic [7:0] port_prev;
    logic [7:0] port_mode;
    logic [15:0] mask;
    logic [15:0] next_flags;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] rd_mux;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    // ****************************************************************
    // port input synchroniser
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            port_meta <= 8'h00;
            port_sync <= 8'h00;
            port_prev <= 8'h00;
        end else begin
            port_meta <= PORT_IN;
            port_sync <= port_meta;
            port_prev <= port_sync;
        end
    end

    // ****************************************************************
    // level fields
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            LEVELS.conv_range_level <= ICL_RST_LEVEL;
            LEVELS.serial_ch1_level <= ICL_RST_LEVEL;
            LEVELS.remote_ctrl_level <= ICL_RST_LEVEL;
        end else if (BUS.wr) begin
            if (hit(BUS.addr, ICL_OFS_CONV_LEVEL)) begin
                LEVELS.conv_range_level <= BUS.wdata[ICL_POS_CONV_LEVEL +: 3];
            end
            if (hit(BUS.addr, ICL_OFS_SER1_LEVEL)) begin
                LEVELS.serial_ch1_level <= BUS.wdata[ICL_POS_SER1_LEVEL +: 3];
            end
            if (hit(BUS.addr, ICL_OFS_REMOTE_LEVEL)) begin
                LEVELS.remote_ctrl_level <= BUS.wdata[ICL_POS_REMOTE_LEVEL +: 3];
            end
        end
    end

    // ****************************************************************
    // port trigger mode and mask
    // ****************************************************************
    // port_mode bit high selects level trigger, low selects pulse trigger
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            port_mode <= ICL_RST_PORT_MODE;
            mask <= ICL_RST_MASK;
        end else if (BUS.wr) begin
            if (hit(BUS.addr, ICL_OFS_PORT_MODE)) begin
                port_mode <= BUS.wdata[7:0];
            end
            if (hit(BUS.addr, ICL_OFS_MASK)) begin
                mask <= BUS.wdata & ICL_FLAG_BITS;
            end
        end
    end

    // ****************************************************************
    // flag set and clear
    // ****************************************************************
    always_comb begin
        set_vec = 16'h0000;
        set_vec[ICL_POS_I2C_MASTER] = PERIPH_REQ.i2c_master;
        set_vec[ICL_POS_SERIAL_CH0] = PERIPH_REQ.serial_ch0;
        set_vec[ICL_POS_UART] = PERIPH_REQ.uart;
        set_vec[ICL_POS_TIMER_A] = PERIPH_REQ.timer_a;
        set_vec[ICL_POS_TIMER_B] = PERIPH_REQ.timer_b;
        set_vec[ICL_POS_TIMER_C] = PERIPH_REQ.timer_c;
        set_vec[ICL_POS_TIMER_D] = PERIPH_REQ.timer_d;
        // pulse mode catches a rising edge, level mode follows the input
        set_vec[ICL_POS_PORT +: ICL_NUM_PORTS] =
            (port_mode & port_sync) | (~port_mode & port_sync & ~port_prev);
        clr_vec = 16'h0000;
        if (BUS.wr && hit(BUS.addr, ICL_OFS_FLAG)) begin
            clr_vec = BUS.wdata & ICL_FLAG_BITS;
            // software cannot clear a level-triggered port flag
            clr_vec[ICL_POS_PORT +: ICL_NUM_PORTS] =
                BUS.wdata[ICL_POS_PORT +: ICL_NUM_PORTS] & ~port_mode;
        end
        // level-mode flags drop by hardware once the input is released
        clr_vec[ICL_POS_PORT +: ICL_NUM_PORTS] = clr_vec[ICL_POS_PORT +: ICL_NUM_PORTS]
            | (port_mode & ~port_sync);
        // a new cause in the clearing cycle is kept: set wins
        next_flags = ((FLAGS & ~clr_vec) | set_vec) & ICL_FLAG_BITS;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            FLAGS <= ICL_RST_FLAG;
        end else begin
            FLAGS <= next_flags;
        end
    end

    // ****************************************************************
    // interrupt output
    // ****************************************************************
    // taken from next_flags so IRQ stays in step with FLAGS
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(next_flags & mask);
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb begin
        rd_mux = 16'h0000;
        unique case (BUS.addr)
            ICL_OFS_CONV_LEVEL: rd_mux[ICL_POS_CONV_LEVEL +: 3] = LEVELS.conv_range_level;
            ICL_OFS_SER1_LEVEL: rd_mux[ICL_POS_SER1_LEVEL +: 3] = LEVELS.serial_ch1_level;
            ICL_OFS_REMOTE_LEVEL: rd_mux[ICL_POS_REMOTE_LEVEL +: 3] = LEVELS.remote_ctrl_level;
            ICL_OFS_FLAG: rd_mux = FLAGS;
            ICL_OFS_PORT_MODE: rd_mux[7:0] = port_mode;
            ICL_OFS_MASK: rd_mux = mask;
            default: rd_mux = 16'h0000;
        endcase
    end

    // read data stand one cycle after the strobe and only then
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= ICL_RST_RDATA;
        end else if (BUS.rd) begin
            RDATA <= rd_mux;
        end else begin
            RDATA <= ICL_RST_RDATA;
        end
    end

endmodule

/* File: sim/icl_regs_properties.sv */
/* Checker for the level fields and flag register.
   Assumes it is bound to icl_regs and sees only its ports. */
`timescale 1ns/10ps
module icl_regs_chk (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // watched ports
    input wire icl_pkg::icl_bus_req_t BUS,
    input wire logic [15:0] RDATA,
    input wire icl_pkg::icl_periph_req_t PERIPH_REQ,
    input wire logic [7:0] PORT_IN,
    input wire logic [15:0] FLAGS,
    input wire icl_pkg::icl_levels_t LEVELS,
    input wire logic IRQ
);
    import icl_pkg::*;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    rdata_idle_a: assert property (!$past(BUS.rd) |-> RDATA == 16'h0000)
        else $error("read data outside read slot");
    flag_rsvd_a: assert property (FLAGS[13] == 1'b0)
        else $error("reserved flag bit set");
    ser_set_a: assert property (PERIPH_REQ.serial_ch0 |=> FLAGS[14])
        else $error("serial flag not set");
    ser_cause_a: assert property ($rose(FLAGS[14]) |-> $past(PERIPH_REQ.serial_ch0))
        else $error("serial flag set without cause");
    ser_clear_a: assert property (BUS.wr && BUS.addr == ICL_OFS_FLAG && BUS.wdata[14]
        && !PERIPH_REQ.serial_ch0 |=> !FLAGS[14]) else $error("serial flag not cleared");
    timer_set_a: assert property (PERIPH_REQ[3:0] != 4'h0
        |=> (FLAGS[11:8] & $past(PERIPH_REQ[3:0])) == $past(PERIPH_REQ[3:0]))
        else $error("timer flag not set");
    level_hold_a: assert property (!BUS.wr |=> $stable(LEVELS))
        else $error("level changed without write");
    level_write_a: assert property (BUS.wr && BUS.addr == ICL_OFS_REMOTE_LEVEL
        |=> LEVELS.remote_ctrl_level == $past(BUS.wdata[2:0])) else $error("level not written");
    port_cause_a: assert property ($rose(FLAGS[0]) |-> $past(PORT_IN[0], 3))
        else $error("port flag set without pin");
    irq_cause_a: assert property (IRQ |-> FLAGS != 16'h0000)
        else $error("interrupt without flag");
endmodule
bind icl_regs icl_regs_chk i_icl_regs_chk (.CLK_SYS, .RST_N, .BUS, .RDATA, .PERIPH_REQ,
    .PORT_IN, .FLAGS, .LEVELS, .IRQ);

/* File: sim/icl_src_model.sv */
/* Peripheral request sources feeding the flag register.
   Assumes the bench asks for a burst in step with CLK_SYS. */
`timescale 1ns/10ps
module icl_src_model (
    // clock
    input wire logic CLK_SYS,
    // bench control
    input wire logic FIRE,
    input wire logic [6:0] SRC_SEL,
    // towards the block
    output icl_pkg::icl_periph_req_t PERIPH_REQ
);
    import icl_pkg::*;
    // real sources pulse for exactly one cycle, never a level
    always_ff @(posedge CLK_SYS) begin
        PERIPH_REQ <= FIRE ? icl_periph_req_t'(SRC_SEL) : icl_periph_req_t'(7'h00);
    end
endmodule

/* File: sim/icl_regs_tb.sv */
/* Self-checking bench for the level fields and flag register.
   Assumes icl_regs, icl_src_model and the bound checker. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module icl_regs_tb;
    import icl_pkg::*;
    logic CLK_SYS = 0, RST_N = 0, fire = 0, irq;
    logic [6:0] src_sel = 7'h00;
    logic [7:0] port_in = 8'h00;
    logic [15:0] rdata, flags;
    logic [15:0] offs [5] = '{ICL_OFS_CONV_LEVEL, ICL_OFS_SER1_LEVEL, ICL_OFS_REMOTE_LEVEL,
        ICL_OFS_FLAG, 16'h4302};
    icl_bus_req_t bus = '0;
    icl_periph_req_t periph_req;
    icl_levels_t levels;
    int err_total = 0, compares = 0, exp_flags = 0, exp_mask = 0, m;
    always #25 CLK_SYS = ~CLK_SYS;
    icl_regs i_icl_regs (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .BUS(bus), .RDATA(rdata),
        .PERIPH_REQ(periph_req), .PORT_IN(port_in), .FLAGS(flags), .LEVELS(levels), .IRQ(irq));
    icl_src_model i_icl_src_model (.CLK_SYS(CLK_SYS), .FIRE(fire), .SRC_SEL(src_sel),
        .PERIPH_REQ(periph_req));
    // ****************************************************************
    // bus cycles and comparisons
    // ****************************************************************
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK_SYS);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK_SYS);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input int e);
        @(posedge CLK_SYS);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge CLK_SYS);
        bus.rd <= 1'b0;
        #1;
        `CHK("rdata", e[15:0], rdata)
    endtask
    task automatic fire_src(input logic [6:0] s);
        @(posedge CLK_SYS);
        fire <= 1'b1;
        src_sel <= s;
        @(posedge CLK_SYS);
        fire <= 1'b0;
        @(posedge CLK_SYS);
        #1;
        exp_flags |= {s[6:5], 1'b0, s[4:0], 8'h00};
    endtask
    task automatic sync();
        `CHK("flags", exp_flags[15:0], flags)
        `CHK("irq", (exp_flags & exp_mask) != 0, irq)
    endtask
    task automatic complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        err_total++;
        complete_run();
    end
    initial begin
        void'($urandom(32'haa44_ca42));
        repeat (4) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        foreach (offs[i]) rd(offs[i], 0);
        for (int v = 0; v < 8; v++) begin
            m = $urandom;
            wr(ICL_OFS_CONV_LEVEL, {m[15:11], v[2:0], m[7:0]});
            wr(ICL_OFS_SER1_LEVEL, {m[15:3], 3'(7 - v)});
            wr(ICL_OFS_REMOTE_LEVEL, {m[12:0], v[2:0]});
            `CHK("levels", {v[2:0], 3'(7 - v), v[2:0]}, levels)
            rd(ICL_OFS_CONV_LEVEL, v << 8);
            rd(ICL_OFS_SER1_LEVEL, 7 - v);
            rd(ICL_OFS_REMOTE_LEVEL, v);
        end
        wr(16'h4302, 16'hffff);
        rd(16'h4302, 0);
        wr(ICL_OFS_MASK, 16'h40f0);
        exp_mask = 16'h40f0;
        rd(ICL_OFS_MASK, 16'h40f0);
        repeat (6) begin
            m = $urandom;
            fire_src(m[6:0]);
            sync();
            rd(ICL_OFS_FLAG, exp_flags);
            m = $urandom;
            wr(ICL_OFS_FLAG, m[15:0]);
            exp_flags &= ~m;
            sync();
        end
        // low four ports in level mode, high four in pulse mode
        wr(ICL_OFS_PORT_MODE, 16'h000f);
        @(posedge CLK_SYS);
        port_in <= 8'hff;
        repeat (4) @(posedge CLK_SYS);
        #1 exp_flags |= 16'h00ff;
        sync();
        wr(ICL_OFS_FLAG, 16'h00ff);
        exp_flags &= ~16'h00f0;
        sync();
        @(posedge CLK_SYS);
        port_in <= 8'h00;
        repeat (4) @(posedge CLK_SYS);
        #1 exp_flags &= ~16'h000f;
        sync();
        complete_run();
    end
endmodule
